// [common/pap_map.svh]
// register offsets, field positions and reset values of the port A pin block
`ifndef PAP_MAP_SVH
`define PAP_MAP_SVH

`define PAP_OFF_LEVELS     8'h00
`define PAP_OFF_LATCH      8'h04
`define PAP_OFF_DIR        8'h08
`define PAP_OFF_CFG        8'h0C

`define PAP_RST_LATCH      6'h00
`define PAP_RST_DIR        6'h3F
`define PAP_RST_CFG        6'h00
`define PAP_RST_PU         1'b0

`define PAP_ANALOG_PIN_SELECT_DIG_FROM  4'h7
`define PAP_ANALOG_PIN_SELECT_TOP       4'h6
`define PAP_BIT_VCFG0      4
`define PAP_BIT_VCFG1      5
`define PAP_PIN_VREF_NEG   2
`define PAP_PIN_VREF_POS   3
`define PAP_PIN_TMR0       4
`define PAP_BIT_PU_HI      7
`define PAP_BIT_PU_LO      6

`define PAP_RESP_OKAY      2'h0
`define PAP_RESP_SLVERR    2'h2

`endif

// [common/pap_pkg.sv]
// types shared by the port A pin block
`default_nettype none
`include "pap_map.svh"
package pap_pkg;
    typedef enum logic [2:0] {
        PAP_SEL_LEVELS = 3'h0,
        PAP_SEL_LATCH  = 3'h1,
        PAP_SEL_DIR    = 3'h2,
        PAP_SEL_CFG    = 3'h3,
        PAP_SEL_NONE   = 3'h4
    } pap_sel_t;

    typedef enum logic [0:0] {
        PAP_CH_IDLE = 1'b0,
        PAP_CH_RESP = 1'b1
    } pap_chan_t;

    // address decode used by both the write and the read path
    function automatic pap_sel_t pap_decode(input logic [7:0] addr);
        pap_sel_t s;
        s = PAP_SEL_NONE;
        if (addr == `PAP_OFF_LEVELS) begin
            s = PAP_SEL_LEVELS;
        end else if (addr == `PAP_OFF_LATCH) begin
            s = PAP_SEL_LATCH;
        end else if (addr == `PAP_OFF_DIR) begin
            s = PAP_SEL_DIR;
        end else if (addr == `PAP_OFF_CFG) begin
            s = PAP_SEL_CFG;
        end
        return s;
    endfunction
endpackage
`default_nettype wire

// [common/pap_reg_if.sv]
// register access strobes between the bus slave and the pin logic
`default_nettype none
interface pap_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                   input wr_ok, rd_data, rd_ok);
    modport regs  (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                   output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// [logic/pap_axil.sv]
// axi4-lite slave front end turning bus transfers into register strobes
`default_nettype none
`include "pap_map.svh"
module pap_axil (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    pap_reg_if.slave         rif
);
    logic             aw_held_reg;
    logic             w_held_reg;
    logic             ar_held_reg;
    pap_pkg::pap_chan_t wst_reg;

    // write fires once both address and data are held, one cycle after the later one
    assign rif.wr_en = aw_held_reg && w_held_reg && (wst_reg == pap_pkg::PAP_CH_IDLE);
    assign rif.rd_en = ar_held_reg && !rvalid;

    // write address and data are taken in either order
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awready     <= 1'b1;
            wready      <= 1'b1;
            rif.wr_addr <= 8'h00;
            rif.wr_data <= 32'h0000_0000;
            rif.wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                awready     <= 1'b0;
                rif.wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_reg  <= 1'b1;
                wready      <= 1'b0;
                rif.wr_data <= wdata;
                rif.wr_strb <= wstrb;
            end
            if (rif.wr_en) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // write response; ready stays low until the response is taken
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wst_reg <= pap_pkg::PAP_CH_IDLE;
            bvalid  <= 1'b0;
            bresp   <= `PAP_RESP_OKAY;
        end else begin
            case (wst_reg)
                pap_pkg::PAP_CH_IDLE: begin
                    if (rif.wr_en) begin
                        wst_reg <= pap_pkg::PAP_CH_RESP;
                        bvalid  <= 1'b1;
                        bresp   <= rif.wr_ok ? `PAP_RESP_OKAY : `PAP_RESP_SLVERR;
                    end
                end
                pap_pkg::PAP_CH_RESP: begin
                    if (bready) begin
                        wst_reg <= pap_pkg::PAP_CH_IDLE;
                        bvalid  <= 1'b0;
                    end
                end
                default: wst_reg <= pap_pkg::PAP_CH_IDLE;
            endcase
        end
    end

    // read channel: address taken, data returned on the next edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ar_held_reg <= 1'b0;
            arready     <= 1'b1;
            rvalid      <= 1'b0;
            rdata       <= 32'h0000_0000;
            rresp       <= `PAP_RESP_OKAY;
            rif.rd_addr <= 8'h00;
        end else begin
            if (arvalid && arready) begin
                ar_held_reg <= 1'b1;
                arready     <= 1'b0;
                rif.rd_addr <= araddr;
            end
            if (rif.rd_en) begin
                ar_held_reg <= 1'b0;
                rvalid      <= 1'b1;
                rdata       <= rif.rd_data;
                rresp       <= rif.rd_ok ? `PAP_RESP_OKAY : `PAP_RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [logic/pap_decode.sv]
// converter pin configuration decode into analog and reference selects
`default_nettype none
`include "pap_map.svh"
module pap_decode (
    input  wire logic [5:0] cfg,
    output logic [4:0]      analog_ch,
    output logic            vref_neg_sel,
    output logic            vref_pos_sel
);
    // analog_pin_select below the all-digital code makes channels 0..(6-code) analog
    function automatic logic [4:0] pap_ch_mask(input logic [3:0] sel);
        logic [4:0] m;
        m = 5'h00;
        for (int k = 0; k < 5; k++) begin
            if ((sel < `PAP_ANALOG_PIN_SELECT_DIG_FROM) && (4'(k) <= (`PAP_ANALOG_PIN_SELECT_TOP - sel))) begin
                m[k] = 1'b1;
            end
        end
        return m;
    endfunction

    // reference_source_select bits route pins 2 and 3 to the references
    always_comb begin
        analog_ch    = pap_ch_mask(cfg[3:0]);
        vref_neg_sel = cfg[`PAP_BIT_VCFG1];
        vref_pos_sel = cfg[`PAP_BIT_VCFG0];
    end
endmodule
`default_nettype wire

// [logic/pap_top.sv]
// six-bit port A pin control with register file on axi4-lite
`default_nettype none
`include "pap_map.svh"
module pap_top #(
    parameter bit HAS_PORT_J = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [5:0]  pad_in,
    output logic [5:0]       pad_out,
    output logic [5:0]       pad_oe,
    input  wire logic        net_led_first_en,
    input  wire logic        net_led_first,
    input  wire logic        net_led_second_en,
    input  wire logic        net_led_second,
    input  wire logic        comparator_reference_output_en,
    input  wire logic        comparator_pos_input_en,
    output logic             timer0_external_clock,
    output logic [4:0]       analog_ch_sel,
    output logic             vref_neg_sel,
    output logic             vref_pos_sel,
    output logic             port_j_pullup_enable,
    output logic             port_d_pullup_enable,
    output logic             port_e_pullup_enable
);
    pap_reg_if rif ();

    logic [5:0]        latch_reg;
    logic [5:0]        dir_reg;
    logic [5:0]        cfg_reg;
    logic [5:0]        level_reg;
    logic              pu_j_reg;
    logic              pu_d_reg;
    logic              pu_e_reg;
    logic [4:0]        analog_ch;
    logic              vref_neg;
    logic              vref_pos;
    logic [5:0]        analog_pin;
    logic [5:0]        input_off;
    logic [5:0]        drive_off;
    logic [5:0]        out_next;
    pap_pkg::pap_sel_t wr_sel;
    pap_pkg::pap_sel_t rd_sel;
    logic              wr_lane0;

    pap_axil u_axil (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rif     (rif)
    );

    pap_decode u_decode (
        .cfg          (cfg_reg),
        .analog_ch    (analog_ch),
        .vref_neg_sel (vref_neg),
        .vref_pos_sel (vref_pos)
    );

    // register selects; only byte lane 0 carries implemented bits
    assign wr_sel     = pap_pkg::pap_decode(rif.wr_addr);
    assign rd_sel     = pap_pkg::pap_decode(rif.rd_addr);
    assign wr_lane0   = rif.wr_en && rif.wr_strb[0];
    assign rif.wr_ok  = (wr_sel != pap_pkg::PAP_SEL_NONE);
    assign rif.rd_ok  = (rd_sel != pap_pkg::PAP_SEL_NONE);

    // channel map: pins 0-3 are channels 0-3, pin 4 has no analog use, pin 5 is channel 4
    always_comb begin
        analog_pin    = {analog_ch[4], 1'b0, analog_ch[3:0]};
        analog_pin[`PAP_PIN_VREF_NEG] = analog_ch[2] | vref_neg | comparator_pos_input_en;
        analog_pin[`PAP_PIN_VREF_POS] = analog_ch[3] | vref_pos;
        input_off     = analog_pin;
        input_off[`PAP_PIN_VREF_NEG] = analog_pin[`PAP_PIN_VREF_NEG] | comparator_reference_output_en;
        drive_off     = dir_reg;
        drive_off[`PAP_PIN_VREF_NEG] = dir_reg[`PAP_PIN_VREF_NEG] | comparator_reference_output_en;
    end

    // output data: latch, with the led signals taking priority on bits 0 and 1 when dir_reg makes those pins outputs
    always_comb begin
        out_next = latch_reg;
        if (net_led_first_en && !dir_reg[0]) begin
            out_next[0] = net_led_first;
        end
        if (net_led_second_en && !dir_reg[1]) begin
            out_next[1] = net_led_second;
        end
    end

    // pad drive is registered so the pins never see decode glitches
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pad_out <= `PAP_RST_LATCH;
            pad_oe  <= 6'h00;
        end else begin
            pad_out <= out_next;
            pad_oe  <= ~drive_off;
        end
    end

    // pin sampling; analog pins read zero so a floating analog level never leaks in
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level_reg <= 6'h00;
        end else begin
            level_reg <= pad_in & ~input_off;
        end
    end

    // timer 0 clock taken straight from pin 4, direction plays no part
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timer0_external_clock <= 1'b0;
        end else begin
            timer0_external_clock <= pad_in[`PAP_PIN_TMR0];
        end
    end

    // analog and reference routing toward the converter and comparator
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            analog_ch_sel <= 5'h00;
            vref_neg_sel  <= 1'b0;
            vref_pos_sel  <= 1'b0;
        end else begin
            analog_ch_sel <= analog_ch;
            vref_neg_sel  <= vref_neg;
            vref_pos_sel  <= vref_pos;
        end
    end

    // output latch; a levels write lands here as well
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            latch_reg <= `PAP_RST_LATCH;
        end else if (wr_lane0 && ((wr_sel == pap_pkg::PAP_SEL_LATCH) ||
                                  (wr_sel == pap_pkg::PAP_SEL_LEVELS))) begin
            latch_reg <= rif.wr_data[5:0];
        end
    end

    // direction and converter configuration; both reset so analog pins start as inputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dir_reg <= `PAP_RST_DIR;
            cfg_reg <= `PAP_RST_CFG;
        end else if (wr_lane0 && (wr_sel == pap_pkg::PAP_SEL_DIR)) begin
            dir_reg <= rif.wr_data[5:0];
        end else if (wr_lane0 && (wr_sel == pap_pkg::PAP_SEL_CFG)) begin
            cfg_reg <= rif.wr_data[5:0];
        end
    end

    // pull-up enables for the other ports ride in spare latch and levels bits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pu_d_reg <= `PAP_RST_PU;
            pu_e_reg <= `PAP_RST_PU;
            pu_j_reg <= `PAP_RST_PU;
        end else begin
            if (wr_lane0 && (wr_sel == pap_pkg::PAP_SEL_LATCH)) begin
                pu_d_reg <= rif.wr_data[`PAP_BIT_PU_HI];
                pu_e_reg <= rif.wr_data[`PAP_BIT_PU_LO];
            end
            if (wr_lane0 && (wr_sel == pap_pkg::PAP_SEL_LEVELS)) begin
                pu_j_reg <= HAS_PORT_J & rif.wr_data[`PAP_BIT_PU_HI];
            end
        end
    end

    // the pull-up levels leave through their own flops
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port_j_pullup_enable <= `PAP_RST_PU;
            port_d_pullup_enable <= `PAP_RST_PU;
            port_e_pullup_enable <= `PAP_RST_PU;
        end else begin
            port_j_pullup_enable <= pu_j_reg;
            port_d_pullup_enable <= pu_d_reg;
            port_e_pullup_enable <= pu_e_reg;
        end
    end

    // read mux; missing bits and unmapped words return zero
    always_comb begin
        rif.rd_data = 32'h0000_0000;
        if (rd_sel == pap_pkg::PAP_SEL_LEVELS) begin
            rif.rd_data[7:0] = {HAS_PORT_J & pu_j_reg, 1'b0, level_reg};
        end else if (rd_sel == pap_pkg::PAP_SEL_LATCH) begin
            rif.rd_data[7:0] = {pu_d_reg, pu_e_reg, latch_reg};
        end else if (rd_sel == pap_pkg::PAP_SEL_DIR) begin
            rif.rd_data[7:0] = {2'b00, dir_reg};
        end else if (rd_sel == pap_pkg::PAP_SEL_CFG) begin
            rif.rd_data[7:0] = {2'b00, cfg_reg};
        end
    end

    // checks next to the logic they guard
    sequence s_wr_levels;
        wr_lane0 && (wr_sel == pap_pkg::PAP_SEL_LEVELS);
    endsequence

    sequence s_wr_latch;
        wr_lane0 && (wr_sel == pap_pkg::PAP_SEL_LATCH);
    endsequence

    property p_pin5_drive;
        @(posedge mclk) disable iff (!rst_n)
        !dir_reg[5] |=> pad_oe[5] && (pad_out[5] == $past(latch_reg[5]));
    endproperty
    a_pin5_drive: assert property (p_pin5_drive) else $error("pin 5 not driven from latch");

    property p_analog_reads_zero;
        @(posedge mclk) disable iff (!rst_n)
        analog_pin[0] |=> (level_reg[0] == 1'b0);
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero) else $error("analog pin 0 read nonzero");

    property p_led_priority;
        @(posedge mclk) disable iff (!rst_n)
        net_led_first_en && !dir_reg[0] |=> pad_out[0] == $past(net_led_first);
    endproperty
    a_led_priority: assert property (p_led_priority) else $error("led did not override latch");

    property p_reset_analog;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> (cfg_reg == `PAP_RST_CFG) ##1 (analog_ch_sel == 5'h1F);
    endproperty
    a_reset_analog: assert property (p_reset_analog) else $error("pins not analog after reset");

    property p_timer_clock;
        @(posedge mclk) disable iff (!rst_n)
        $changed(pad_in[4]) |=> timer0_external_clock == $past(pad_in[4]);
    endproperty
    a_timer_clock: assert property (p_timer_clock) else $error("timer clock not following pin 4");

    property p_comparator_reference_output_blocks;
        @(posedge mclk) disable iff (!rst_n)
        comparator_reference_output_en |=> !pad_oe[2] && !level_reg[2];
    endproperty
    a_comparator_reference_output_blocks: assert property (p_comparator_reference_output_blocks) else $error("pin 2 active under reference output");

    property p_levels_write;
        logic [5:0] d;
        @(posedge mclk) disable iff (!rst_n)
        (s_wr_levels, d = rif.wr_data[5:0]) |=> (latch_reg == d) ##1 (pad_out[5] == d[5]) || dir_reg[5];
    endproperty
    a_levels_write: assert property (p_levels_write) else $error("levels write missed latch");

    property p_unimpl_zero;
        @(posedge mclk) disable iff (!rst_n)
        rif.rd_en && (rd_sel != pap_pkg::PAP_SEL_LEVELS) && (rd_sel != pap_pkg::PAP_SEL_LATCH)
        |=> s_axi_rdata[7:6] == 2'b00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

    property p_pullup_out;
        @(posedge mclk) disable iff (!rst_n)
        s_wr_latch ##2 1'b1 |-> port_d_pullup_enable == $past(rif.wr_data[7], 2);
    endproperty
    a_pullup_out: assert property (p_pullup_out) else $error("pull-up enable not exported");
endmodule
`default_nettype wire

// [dv/pap_pads_model.sv]
// pad-side model: board levels on undriven pins, the block's own drive elsewhere
`default_nettype none
module pap_pads_model (
    input  wire logic [5:0] pad_out,
    input  wire logic [5:0] pad_oe,
    input  wire logic [5:0] board,
    output logic [5:0]      pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driven pin reads back its own level, so output pins are seen by the block too
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & board);
endmodule
`default_nettype wire

// [dv/pap_tb.sv]
// self-checking bench of the port A pin block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [5:0]  pad_in, pad_out, pad_oe, board;
    logic        net_led_first_en, net_led_first, net_led_second_en, net_led_second;
    logic        comparator_reference_output_en, comparator_pos_input_en, timer0_external_clock;
    logic [4:0]  analog_ch_sel;
    logic        vref_neg_sel, vref_pos_sel, port_j_pullup_enable, port_d_pullup_enable, port_e_pullup_enable;
    int          mismatches, checks, cyc;

    pap_top dut (
        .mclk                           (mclk),
        .rst_n                          (rst_n),
        .s_axi_awaddr                   (s_axi_awaddr),
        .s_axi_awvalid                  (s_axi_awvalid),
        .s_axi_awready                  (s_axi_awready),
        .s_axi_wdata                    (s_axi_wdata),
        .s_axi_wstrb                    (s_axi_wstrb),
        .s_axi_wvalid                   (s_axi_wvalid),
        .s_axi_wready                   (s_axi_wready),
        .s_axi_bresp                    (s_axi_bresp),
        .s_axi_bvalid                   (s_axi_bvalid),
        .s_axi_bready                   (s_axi_bready),
        .s_axi_araddr                   (s_axi_araddr),
        .s_axi_arvalid                  (s_axi_arvalid),
        .s_axi_arready                  (s_axi_arready),
        .s_axi_rdata                    (s_axi_rdata),
        .s_axi_rresp                    (s_axi_rresp),
        .s_axi_rvalid                   (s_axi_rvalid),
        .s_axi_rready                   (s_axi_rready),
        .pad_in                         (pad_in),
        .pad_out                        (pad_out),
        .pad_oe                         (pad_oe),
        .net_led_first_en               (net_led_first_en),
        .net_led_first                  (net_led_first),
        .net_led_second_en              (net_led_second_en),
        .net_led_second                 (net_led_second),
        .comparator_reference_output_en (comparator_reference_output_en),
        .comparator_pos_input_en        (comparator_pos_input_en),
        .timer0_external_clock          (timer0_external_clock),
        .analog_ch_sel                  (analog_ch_sel),
        .vref_neg_sel                   (vref_neg_sel),
        .vref_pos_sel                   (vref_pos_sel),
        .port_j_pullup_enable           (port_j_pullup_enable),
        .port_d_pullup_enable           (port_d_pullup_enable),
        .port_e_pullup_enable           (port_e_pullup_enable)
    );
    pap_pads_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .board(board), .pad_in(pad_in));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // both write channels offered at once; trailing wait lets pins and levels settle
    // loop ends on a local flag: the ready strobe set above has not landed yet when first tested
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        repeat (4) @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a);
        logic done;
        done = 1'b0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rv = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(n, rv, e);
    endtask

    // defaults after reset, board pulls every pin high
    task automatic t_reset();
        repeat (3) @(posedge mclk);
        chk("pad_oe", pad_oe, 32'h0);
        chk("analog_ch_sel", analog_ch_sel, 32'h1F);
        rc("levels", 8'h00, 32'h10);
        rc("latch", 8'h04, 32'h00);
        rc("direction", 8'h08, 32'h3F);
        rc("config", 8'h0C, 32'h00);
        chk("timer clock", timer0_external_clock, 32'h1);
    endtask

    // outputs from a levels write; analog selection leaves the drivers alone
    task automatic t_drive();
        wr(8'h0C, 8'h07);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'hE5);
        chk("pad_out", pad_out, 32'h25);
        chk("pad_oe", pad_oe, 32'h3F);
        chk("pu_j", port_j_pullup_enable, 32'h1);
        rc("latch", 8'h04, 32'h25);
        rc("levels", 8'h00, 32'hA5);
        wr(8'h0C, 8'h00);
        chk("pad_out analog", pad_out, 32'h25);
        rc("levels analog", 8'h00, 32'h80);
    endtask

    // spare latch bits are pull-up enables, and clearing the latch clears the pins
    task automatic t_pullup();
        wr(8'h04, 8'hC0);
        chk("pu_d pu_e", {port_d_pullup_enable, port_e_pullup_enable}, 32'h3);
        chk("pad_out", pad_out, 32'h00);
        rc("latch", 8'h04, 32'hC0);
    endtask

    // led overrides on bits 0 and 1 win over the latch
    task automatic t_led();
        wr(8'h04, 8'h02);
        net_led_first_en <= 1'b1;
        net_led_first <= 1'b1;
        net_led_second_en <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("pad_out led", pad_out, 32'h01);
        net_led_first_en <= 1'b0;
        net_led_second_en <= 1'b0;
    endtask

    // input paths, analog select field and the pin 2 disables
    task automatic t_input();
        wr(8'h08, 8'h3F);
        wr(8'h0C, 8'h07);
        chk("analog_ch_sel", analog_ch_sel, 32'h00);
        rc("levels digital", 8'h00, 32'hBF);
        wr(8'h0C, 8'h03);
        chk("analog_ch_sel", analog_ch_sel, 32'h0F);
        rc("levels ch0-3", 8'h00, 32'hB0);
        wr(8'h0C, 8'h07);
        comparator_pos_input_en <= 1'b1;
        rc("levels comp in", 8'h00, 32'hBB);
        comparator_pos_input_en <= 1'b0;
        comparator_reference_output_en <= 1'b1;
        wr(8'h08, 8'h00);
        chk("pad_oe comparator_reference_output", pad_oe, 32'h3B);
        rc("levels comparator_reference_output", 8'h00, 32'h82);
        comparator_reference_output_en <= 1'b0;
    endtask

    // reference routing, timer path on an output pin, unmapped access
    task automatic t_misc();
        wr(8'h0C, 8'h17);
        chk("vref", {vref_neg_sel, vref_pos_sel}, 32'h1);
        wr(8'h0C, 8'h27);
        chk("vref", {vref_neg_sel, vref_pos_sel}, 32'h2);
        wr(8'h04, 8'h10);
        chk("timer clock", timer0_external_clock, 32'h1);
        wr(8'h10, 8'hFF);
        chk("bresp", resp, 32'h2);
        rc("unmapped", 8'h10, 32'h0);
        chk("rresp", resp, 32'h2);
        rc("direction kept", 8'h08, 32'h00);
    endtask

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // hang guard, far above the under two hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        board = 6'h3F;
        {net_led_first_en, net_led_first, net_led_second_en, net_led_second} = 4'h0;
        {comparator_reference_output_en, comparator_pos_input_en} = 2'h0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_drive();
        t_pullup();
        t_led();
        t_input();
        t_misc();
        conclude();
    end
endmodule
`default_nettype wire
